// ---- hdl/two_wire_pkg.sv ----
// Shared constants for the two-wire recovery controller
package two_wire_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  // Control register field positions
  localparam int unsigned STA_BIT = 0;
  localparam int unsigned STO_BIT = 1;
  localparam int unsigned SI_BIT = 2;
  localparam int unsigned AA_BIT = 3;
  localparam int unsigned EN_BIT = 4;
  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // Status codes
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_ARB_38 = 8'h38;
  localparam logic [7:0] CODE_ARB_68 = 8'h68;
  localparam logic [7:0] CODE_ARB_78 = 8'h78;
  localparam logic [7:0] CODE_ARB_B0 = 8'hB0;
  localparam logic [7:0] CODE_BUS_ERR = 8'h00;
  localparam logic [7:0] CODE_NONE = 8'hF8;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SCL_HALF_NS = 1250;
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] PULSES_PER_TRY = 2'h2;
  localparam logic [3:0] FRAME_BITS = 4'h9;
endpackage

// ---- hdl/bus_mon_if.sv ----
// Bus condition signals passed from the line monitor to the controller, and the forced release passed back
interface bus_mon_if;
  logic scl;
  logic sda;
  logic start_det;
  logic stop_det;
  logic busy;
  logic mid_frame;
  logic force_free;
  modport mon (output scl, sda, start_det, stop_det, busy, mid_frame, input force_free);
  modport ctl (input scl, sda, start_det, stop_det, busy, mid_frame, output force_free);
endinterface

// ---- hdl/bus_monitor.sv ----
// Line synchroniser, START/STOP detector, busy and frame position tracker
module bus_monitor
  import two_wire_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  bus_mon_if.mon mon
);
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;
  logic busy_r;
  logic [3:0] bit_cnt_r;

  // Condition decode on synchronised levels
  wire scl_s = scl_sync_r[1];
  wire sda_s = sda_sync_r[1];
  wire start_w = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_w = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;

  // Two-stage synchronisers, then one delay stage for edges
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_pin_in};
      sda_sync_r <= {sda_sync_r[0], sda_pin_in};
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Busy from START until STOP or forced release
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      busy_r <= 1'b0;
    else
      busy_r <= start_w | (busy_r & ~stop_w & ~mon.force_free);
  end

  // Bit position in frame; nonzero means inside a byte or its acknowledge
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || start_w || stop_w)
      bit_cnt_r <= 4'h0;
    else if (scl_rise && bit_cnt_r != FRAME_BITS)
      bit_cnt_r <= bit_cnt_r + 4'h1;
    else if (scl_fall && bit_cnt_r == FRAME_BITS)
      bit_cnt_r <= 4'h0;
  end

  // Outputs to the controller
  assign mon.scl = scl_s;
  assign mon.sda = sda_s;
  assign mon.start_det = start_w;
  assign mon.stop_det = stop_w;
  assign mon.busy = busy_r;
  assign mon.mid_frame = bit_cnt_r != 4'h0;
endmodule

// ---- hdl/two_wire_recovery.sv ----
// Recovery, arbitration retry and bus-error handling of the two-wire controller
// Functional notes
// - Arbitration loss loads 38H, 68H, 78H or B0H
// - Start request after loss retries, entering 08H
// - Spurious START keeps bus busy until STOP
// - Stop with start set: no STOP, bus freed
// - Forced access clears stop request in hardware
// - No recovery while clock line held low
// - Data line low: drive extra clock pulses
// - Retry START after every two pulses
// - Data released: normal START, status 08H
// - Same recovery for forced or repeated START
// - START or STOP mid-frame is bus error
// - Bus errors matter only when taking part
// - Bus error: slave mode, release, flag, 00H
// - Stop write after 00H: release, clear stop
// - Status reads F8H while interrupt flag clear
module two_wire_recovery
  import two_wire_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCL_HALF_CYC
)(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic arb_lost_in,
  input wire logic [1:0] arb_code_in,
  input wire logic addressed_slave_in,
  output logic master_out
);
  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_PLOW, S_PHIGH, S_SHOLD, S_MAST, S_ARB} state_t;

  if (HALF_CYC < 2 || HALF_CYC > 65535)
  begin : g_chk
    $error("HALF_CYC out of range");
  end

  // Arbitration-loss status lookup
  function automatic logic [7:0] arb_code(input logic [1:0] sel);
    logic [7:0] c;
    c = CODE_ARB_38;
    unique case (sel)
      2'h0: c = CODE_ARB_38;
      2'h1: c = CODE_ARB_68;
      2'h2: c = CODE_ARB_78;
      2'h3: c = CODE_ARB_B0;
    endcase
    return c;
  endfunction

  bus_mon_if mon ();
  bus_monitor u_mon (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .scl_pin_in(scl_in),
    .sda_pin_in(sda_in),
    .mon(mon.mon)
  );

  state_t state_r;
  state_t state_nxt;
  logic [15:0] tmr_r;
  logic [1:0] pulse_r;
  logic [1:0] pulse_nxt;
  logic sta_r;
  logic sto_r;
  logic si_r;
  logic aa_r;
  logic en_r;
  logic rep_r;
  logic rep_nxt;
  logic [7:0] code_r;
  logic [7:0] code_nxt;
  logic [7:0] data_r;
  logic set_si;
  logic clr_sto;
  logic force_free;
  logic scl_oe_r;
  logic sda_oe_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic master_r;

  // APB decode
  wire setup = psel_in & ~penable_in;
  wire wr_acc = psel_in & penable_in & pready_r & pwrite_in;
  wire hit_ctrl = paddr_in == CTRL_OFS;
  wire hit_stat = paddr_in == STAT_OFS;
  wire hit_data = paddr_in == DATA_OFS;
  wire mapped = hit_ctrl | hit_stat | hit_data;
  wire ctrl_wr = wr_acc & hit_ctrl;
  wire data_wr = wr_acc & hit_data;
  wire [7:0] stat_view = si_r ? code_r : CODE_NONE;
  wire [31:0] ctrl_view = {27'h000_0000, en_r, aa_r, si_r, sto_r, sta_r};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_view :
                       hit_stat ? {24'h00_0000, stat_view} :
                       {24'h00_0000, data_r};

  // Bus condition decode
  wire tmr_done = tmr_r == 16'h0000;
  wire involved = (state_r == S_MAST) | addressed_slave_in;
  wire bus_err = involved & (mon.start_det | mon.stop_det) & mon.mid_frame;
  wire free_now = ~mon.busy | rep_r;

  // Next state and flag effects
  always_comb
  begin
    state_nxt = state_r;
    code_nxt = code_r;
    set_si = 1'b0;
    clr_sto = 1'b0;
    force_free = 1'b0;
    rep_nxt = rep_r;
    pulse_nxt = pulse_r;
    unique case (state_r)
      S_IDLE:
        if (en_r && sta_r && !si_r)
          state_nxt = S_WAIT;
        else if (sto_r && !sta_r && !si_r)
        begin
          clr_sto = 1'b1;
          force_free = 1'b1;
        end
      S_WAIT:
        if (!en_r || !sta_r)
        begin
          state_nxt = S_IDLE;
          rep_nxt = 1'b0;
        end
        else if (sto_r)
        begin
          clr_sto = 1'b1;
          force_free = 1'b1;
          rep_nxt = 1'b1;
        end
        else if (free_now && mon.scl && tmr_done)
          state_nxt = mon.sda ? S_SHOLD : S_PLOW;
      S_PLOW:
        if (tmr_done)
          state_nxt = S_PHIGH;
      S_PHIGH:
        if (tmr_done && mon.scl)
        begin
          if (pulse_r == PULSES_PER_TRY - 2'h1)
          begin
            pulse_nxt = 2'h0;
            state_nxt = S_WAIT;
          end
          else
          begin
            pulse_nxt = pulse_r + 2'h1;
            state_nxt = S_PLOW;
          end
        end
      S_SHOLD:
        if (tmr_done)
        begin
          state_nxt = S_MAST;
          code_nxt = CODE_START;
          set_si = 1'b1;
          rep_nxt = 1'b0;
        end
      S_MAST:
        if (arb_lost_in)
        begin
          state_nxt = S_ARB;
          code_nxt = arb_code(arb_code_in);
          set_si = 1'b1;
        end
        else if (!si_r && sta_r)
        begin
          state_nxt = S_WAIT;
          rep_nxt = 1'b1;
        end
        else if (!si_r && sto_r)
        begin
          state_nxt = S_IDLE;
          clr_sto = 1'b1;
        end
      S_ARB:
        if (!si_r && sta_r)
          state_nxt = S_WAIT;
        else if (!si_r)
          state_nxt = S_IDLE;
      default:
      begin
        state_nxt = S_IDLE;
        code_nxt = CODE_BUS_ERR;
        set_si = 1'b1;
      end
    endcase
    if (bus_err)
    begin
      state_nxt = S_IDLE;
      code_nxt = CODE_BUS_ERR;
      set_si = 1'b1;
      rep_nxt = 1'b0;
      pulse_nxt = 2'h0;
    end
  end

  assign mon.force_free = force_free;

  // Line drive decode on next state
  wire scl_oe_nxt = (state_nxt == S_MAST) | (state_nxt == S_PLOW);
  wire sda_oe_nxt = (state_nxt == S_SHOLD) | (state_nxt == S_MAST);

  // Sequencer state, half-period timer and line drives
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state_r <= S_IDLE;
      tmr_r <= 16'h0000;
      pulse_r <= 2'h0;
      rep_r <= 1'b0;
      code_r <= CODE_NONE;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      master_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r <= (state_nxt != state_r) ? 16'(HALF_CYC - 1) : tmr_done ? tmr_r : tmr_r - 16'h0001;
      pulse_r <= pulse_nxt;
      rep_r <= rep_nxt;
      code_r <= code_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      master_r <= state_nxt == S_MAST;
    end
  end

  // Control flags; hardware set of the flag wins over software clear
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      {en_r, aa_r, si_r, sto_r, sta_r} <= CTRL_RST;
      data_r <= DATA_RST;
    end
    else
    begin
      si_r <= set_si | (si_r & ~(ctrl_wr & ~pwdata_in[SI_BIT]));
      sto_r <= ctrl_wr ? pwdata_in[STO_BIT] : (sto_r & ~clr_sto);
      sta_r <= ctrl_wr ? pwdata_in[STA_BIT] : sta_r;
      aa_r <= ctrl_wr ? pwdata_in[AA_BIT] : aa_r;
      en_r <= ctrl_wr ? pwdata_in[EN_BIT] : en_r;
      data_r <= data_wr ? pwdata_in[7:0] : data_r;
    end
  end

  // APB answer: one access cycle, read data captured in setup
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r <= (setup && mapped && !pwrite_in) ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_oe_r;
  assign sda_oe_out = sda_oe_r;
  assign master_out = master_r;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_arb_code_load: assert property (
    state_r == S_MAST && arb_lost_in && !bus_err |=> si_r && state_r == S_ARB &&
      (code_r == CODE_ARB_38 || code_r == CODE_ARB_68 ||
       code_r == CODE_ARB_78 || code_r == CODE_ARB_B0))
    else $error("arbitration loss code not loaded");
  a_start_code_08: assert property (
    state_r == S_SHOLD && tmr_done && !bus_err |=> si_r && code_r == CODE_START
      && scl_oe_r && sda_oe_r)
    else $error("START did not report 08H");
  a_busy_no_start: assert property (
    state_r == S_WAIT && mon.busy && !rep_r && !sto_r |=> !sda_oe_r)
    else $error("START driven on busy bus");
  a_forced_access: assert property (
    state_r == S_WAIT && sta_r && sto_r && en_r && !bus_err && !ctrl_wr |=> !sto_r && rep_r
      && state_r == S_WAIT && !sda_oe_r)
    else $error("forced access mishandled");

  a_scl_low_wait: assert property (
    state_r == S_WAIT && !mon.scl && !sto_r && sta_r && en_r && !bus_err |=>
      state_r == S_WAIT && !scl_oe_r && !sda_oe_r)
    else $error("acted while clock line low");

  a_pulse_no_start: assert property (
    state_r == S_PLOW |-> scl_oe_r && !sda_oe_r)
    else $error("clock pulse phase wrong");

  a_two_pulses: assert property (
    state_r == S_PHIGH && tmr_done && mon.scl && pulse_r == 2'h1 && !bus_err
      |=> state_r == S_WAIT && pulse_r == 2'h0)
    else $error("no START attempt after two pulses");

  a_bus_error: assert property (
    bus_err |=> state_r == S_IDLE && si_r && code_r == CODE_BUS_ERR
      && !scl_oe_r && !sda_oe_r)
    else $error("bus error reaction wrong");

  a_err_recover: assert property (
    state_r == S_IDLE && sto_r && !sta_r && !si_r && !ctrl_wr && !bus_err |=> !sto_r
      && !scl_oe_r && !sda_oe_r)
    else $error("stop request not cleared");

  a_idle_status: assert property (
    setup && hit_stat && !pwrite_in && !si_r |=> prdata_r == {24'h00_0000, CODE_NONE})
    else $error("status not F8H with flag clear");
endmodule

// ---- sim/bus_partner.sv ----
// Other devices on the two-wire bus: pull-ups and their own pull-downs
module bus_partner (
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_low_r = 1'b0;
  logic sda_low_r = 1'b0;
  // Wired-AND of every pull-down against the pull-ups
  assign scl_out = ~(scl_oe_in | scl_low_r);
  assign sda_out = ~(sda_oe_in | sda_low_r);
  // One half period of the far side's link clock
  task automatic line(input logic c, input logic d);
    #5;
    scl_low_r = c;
    sda_low_r = d;
    #27;
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Register-level bench for the two-wire recovery controller
module tb_top
  import two_wire_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0, arb = 0, adr_sl = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_v;
  logic [1:0] arb_code = 2'h0;
  logic pready, pslverr, scl, sda, scl_oe, sda_oe, master, er_v;
  logic [7:0] codes [4] = '{CODE_ARB_38, CODE_ARB_68, CODE_ARB_78, CODE_ARB_B0};
  int error_cnt = 0;
  int cmp_count = 0;
  int pulses = 0;
  two_wire_recovery #(.HALF_CYC(4)) DUT (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe_out(sda_oe), .arb_lost_in(arb), .arb_code_in(arb_code),
    .addressed_slave_in(adr_sl), .master_out(master));
  bus_partner p (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  // Clock
  always #4 core_clk_in = ~core_clk_in;
  // Extra clock pulses driven by the controller
  always @(posedge scl_oe) pulses++;
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    pen <= 1'b1;
    do @(posedge core_clk_in); while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd_v);
  endtask
  // Far-side line step, then back on the clock
  task automatic ln(input logic c, input logic d);
    p.line(c, d);
    @(posedge core_clk_in);
  endtask
  // Bounded wait for bus ownership
  task automatic wait_m(input string nm);
    int n;
    n = 0;
    while (master !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk_in);
      n++;
    end
    chk(nm, 32'h0000_0001, {31'h0, master});
  endtask
  task automatic idle_chk(input string nm);
    repeat (60) @(posedge core_clk_in);
    chk(nm, 32'h0000_0000, {31'h0, master});
  endtask
  // Release ownership, then a START-STOP pair frees the bus
  task automatic free_bus();
    wr(CTRL_OFS, 32'h0000_0012);
    ln(1'b0, 1'b1);
    ln(1'b0, 1'b0);
  endtask
  // START, four bits, then STOP inside the byte
  task automatic err_seq();
    ln(1'b0, 1'b1);
    ln(1'b1, 1'b1);
    repeat (3)
    begin
      ln(1'b0, 1'b1);
      ln(1'b1, 1'b1);
    end
    ln(1'b0, 1'b1);
    ln(1'b0, 1'b0);
    repeat (10) @(posedge core_clk_in);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #400_000;
    error_cnt++;
    final_report();
  end
  // Test sequence
  initial
  begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    rd(STAT_OFS, 32'h0000_00F8, "status idle");
    rd(CTRL_OFS, 32'h0000_0000, "ctrl reset");
    wr(DATA_OFS, 32'h0000_005A);
    rd(DATA_OFS, 32'h0000_005A, "data");
    chk("mapped err", 32'h0000_0000, {31'h0, er_v});
    wr(CTRL_OFS, 32'h0000_000C);
    rd(CTRL_OFS, 32'h0000_0008, "ack flag kept");
    rd(STAT_OFS, 32'h0000_00F8, "flag not set by write");
    rd(8'h0C, 32'h0000_0000, "unmapped data");
    chk("unmapped err", 32'h0000_0001, {31'h0, er_v});
    $display("test registers done");
    wr(CTRL_OFS, 32'h0000_0011);
    wait_m("first start");
    chk("start drive", 32'h0000_0003, {30'h0, scl_oe, sda_oe});
    for (int i = 0; i < 4; i++)
    begin
      arb_code <= i[1:0];
      arb <= 1'b1;
      @(posedge core_clk_in);
      arb <= 1'b0;
      @(posedge core_clk_in);
      rd(STAT_OFS, {24'h0, codes[i]}, "arb code");
      wr(CTRL_OFS, 32'h0000_0011);
      idle_chk("retry waits");
      ln(1'b0, 1'b1);
      ln(1'b0, 1'b0);
      wait_m("retry start");
      rd(STAT_OFS, {24'h0, CODE_START}, "retry status");
    end
    free_bus();
    $display("test arbitration done");
    wr(CTRL_OFS, 32'h0000_0010);
    err_seq();
    rd(STAT_OFS, 32'h0000_00F8, "error ignored");
    adr_sl <= 1'b1;
    err_seq();
    rd(STAT_OFS, {24'h0, CODE_BUS_ERR}, "bus error");
    chk("error release", 32'h0000_0000, {30'h0, scl_oe, sda_oe});
    rd(CTRL_OFS, 32'h0000_0014, "error flag");
    adr_sl <= 1'b0;
    wr(CTRL_OFS, 32'h0000_0012);
    rd(CTRL_OFS, 32'h0000_0010, "recover ctrl");
    rd(STAT_OFS, 32'h0000_00F8, "recover status");
    $display("test bus error done");
    wr(CTRL_OFS, 32'h0000_0011);
    wait_m("start free");
    ln(1'b0, 1'b1);
    wr(CTRL_OFS, 32'h0000_0012);
    wr(CTRL_OFS, 32'h0000_0011);
    idle_chk("busy waits");
    pulses = 0;
    wr(CTRL_OFS, 32'h0000_0013);
    rd(CTRL_OFS, 32'h0000_0011, "stop cleared");
    for (int n = 0; n < 3000 && pulses < 4; n++) @(posedge core_clk_in);
    chk("pulses", 32'h0000_0001, {31'h0, pulses >= 4});
    chk("no start on low data", 32'h0000_0000, {31'h0, master});
    ln(1'b0, 1'b0);
    wait_m("start after release");
    rd(STAT_OFS, {24'h0, CODE_START}, "forced status");
    $display("test forced access done");
    free_bus();
    ln(1'b1, 1'b0);
    wr(CTRL_OFS, 32'h0000_0011);
    idle_chk("clock held");
    ln(1'b0, 1'b0);
    wait_m("clock freed");
    wr(CTRL_OFS, 32'h0000_0011);
    @(posedge core_clk_in);
    chk("repeat releases", 32'h0000_0000, {31'h0, master});
    wait_m("repeated start");
    rd(STAT_OFS, {24'h0, CODE_START}, "repeated status");
    free_bus();
    $display("test clock low done");
    final_report();
  end
endmodule
